// file: rtl/status_pkg.sv
// Constants, field layout and types for the front-end status register bank.
// Assumes one 50 MHz clock and an APB master with 32-bit data.
//
// Overview of operation
// - Read-only status word at index 0x07
// - Bit 29 checksum good, resets to one
// - Bit 28 follows subcarrier detection
// - Bit 27 set on start-of-frame recognition
// - Bit 26 shows own transmit drivers on
// - Bit 25 shows filtered external field
// - Bit 24 sticky clipping, cleared by receiver reset
// - Bit 22 loop integrator at zero or maximum
// - Bit 21 loop inside configured saturation range
// - Coarse, fine, superfine frequency lock bits
// - Bit 17 shows loop phase lock
// - Bit 16 shows loop enabled by controller
// - Busy bit while buffer transfer runs
// - Bit 13 late fetch flag, aborts transmission
package status_pkg;

  // Register indices; byte address is four times the index
  localparam int unsigned STATUS_INDEX = 7;
  localparam int unsigned CONTROL_INDEX = 8;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] STATUS_ADDR = 12'(STATUS_INDEX * 4);
  localparam logic [11:0] CONTROL_ADDR = 12'(CONTROL_INDEX * 4);

  // Status word bit positions
  localparam int unsigned CRC_OK_BIT = 29;
  localparam int unsigned SUBCARRIER_BIT = 28;
  localparam int unsigned SOF_BIT = 27;
  localparam int unsigned OWN_FIELD_BIT = 26;
  localparam int unsigned EXT_FIELD_BIT = 25;
  localparam int unsigned Q_CLIP_BIT = 24;
  localparam int unsigned LOOP_LIMIT_BIT = 22;
  localparam int unsigned LOOP_RANGE_BIT = 21;
  localparam int unsigned LOCK_SUPERFINE_BIT = 20;
  localparam int unsigned LOCK_FINE_BIT = 19;
  localparam int unsigned LOCK_COARSE_BIT = 18;
  localparam int unsigned PHASE_LOCK_BIT = 17;
  localparam int unsigned LOOP_ENABLED_BIT = 16;
  localparam int unsigned BUFFER_BUSY_BIT = 14;
  localparam int unsigned TX_READ_ERR_BIT = 13;
  localparam logic [31:0] STATUS_RESET = 32'h2000_0000;

  // Control word layout
  localparam int unsigned CTRL_CRC_INV_BIT = 0;
  localparam int unsigned CTRL_SAT_LSB = 8;
  localparam int unsigned SAT_W = 8;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_MASK = 32'h0000_ff01;

  // Datapath widths and constants
  localparam int unsigned CRC_W = 16;
  localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;
  localparam int unsigned SAMPLE_W = 6;
  localparam logic [5:0] SAMPLE_MIN = 6'h00;
  localparam logic [5:0] SAMPLE_MAX = 6'h3f;
  localparam int unsigned INTEG_W = 10;
  localparam logic [9:0] INTEG_MAX = 10'h3ff;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_ANSWER = 2'b10
  } apb_state_type;

endpackage : status_pkg

// file: rtl/loop_status_if.sv
// Carries the phase loop integrator and its limit flags between modules.
// Assumes both ends share mclk.
`timescale 1ns/1ps
interface loop_status_if;
  logic [status_pkg::INTEG_W-1:0] integrator;
  logic [status_pkg::SAT_W-1:0] saturationSetting;
  logic atLimit;
  logic inRange;

  modport monitor (
    input integrator,
    input saturationSetting,
    output atLimit,
    output inRange
  );
  modport owner (
    output integrator,
    output saturationSetting,
    input atLimit,
    input inRange
  );
endinterface : loop_status_if

// file: rtl/sample_clip_detect.sv
// Sticky clipping flag for the quadrature ADC channel.
// Assumes samples and receiver enable come from logic on mclk.
`timescale 1ns/1ps
module sample_clip_detect (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [status_pkg::SAMPLE_W-1:0] sample,
  input wire logic rxReset,
  output logic clipped
);

  logic next_clipped;
  logic railHit;

  always_comb begin
    railHit = (sample == status_pkg::SAMPLE_MIN) ||
              (sample == status_pkg::SAMPLE_MAX);
    next_clipped = clipped;
    if (rxReset) begin
      next_clipped = 1'b0;
    end
    // A rail hit in the reset cycle still counts
    if (railHit) begin
      next_clipped = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clipped <= 1'b0;
    end else begin
      clipped <= next_clipped;
    end
  end

endmodule : sample_clip_detect

// file: rtl/loop_limit_monitor.sv
// Watches the phase loop integrator against its hard and soft limits.
// Assumes the integrator value is on mclk.
`timescale 1ns/1ps
module loop_limit_monitor (
  input wire logic mclk,
  input wire logic sys_rst,
  loop_status_if.monitor loopBus
);

  logic next_atLimit;
  logic next_inRange;
  logic atLimit;
  logic inRange;
  logic [status_pkg::INTEG_W-1:0] satWide;

  always_comb begin
    satWide = status_pkg::INTEG_W'(loopBus.saturationSetting);
    next_atLimit = (loopBus.integrator == '0) ||
                   (loopBus.integrator == status_pkg::INTEG_MAX);
    next_inRange = (loopBus.integrator <= satWide) ||
                   (loopBus.integrator >= (status_pkg::INTEG_MAX - satWide));
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      atLimit <= 1'b0;
      inRange <= 1'b0;
    end else begin
      atLimit <= next_atLimit;
      inRange <= next_inRange;
    end
  end

  assign loopBus.atLimit = atLimit;
  assign loopBus.inRange = inRange;

endmodule : loop_limit_monitor

// file: rtl/contactless_frontend_status.sv
// Front-end status register bank with an APB slave.
// Assumes every status source and the APB master run on mclk.
// Status sources are same-clock levels; a read shows them two edges late, the limit and sticky flags three.
// The control word at index 8 is local: checksum mode and loop band.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module contactless_frontend_status (
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Field and checksum sources
  input wire logic [status_pkg::CRC_W-1:0] crcValue,
  input wire logic subcarrierSeen,
  input wire logic sofSeen,
  input wire logic ownFieldOn,
  input wire logic externalFieldPresent,
  // Receiver
  input wire logic [status_pkg::SAMPLE_W-1:0] quadratureSample,
  input wire logic rxEnable,
  // Phase loop
  input wire logic [status_pkg::INTEG_W-1:0] loopIntegrator,
  input wire logic loopFrequencyLockSuperfine,
  input wire logic loopFrequencyLockFine,
  input wire logic loopFrequencyLockCoarse,
  input wire logic loopPhaseLocked,
  input wire logic loopEnabled,
  // Buffer, transmit and control word copies
  input wire logic bufferManagerBusy,
  input wire logic txActive,
  input wire logic txFetchLate,
  output logic txAbort,
  output logic crcInverted,
  output logic [status_pkg::SAT_W-1:0] loopSaturationSetting
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  status_pkg::apb_state_type apbState;
  status_pkg::apb_state_type next_apbState;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  logic [31:0] controlWord;
  logic [31:0] next_controlWord;

  logic [31:0] statusWord;
  logic [31:0] next_statusWord;

  logic rxEnablePrev;
  logic next_rxEnablePrev;
  logic rxReset;
  logic sofHeld;
  logic next_sofHeld;
  logic txReadError;
  logic next_txReadError;
  logic txActivePrev;
  logic next_txActivePrev;
  logic next_txAbort;
  logic txStart;

  logic qClipped;
  logic setupPhase;
  logic completing;
  logic hitStatus;
  logic hitControl;

  // Loop limit flags travel in the interface
  loop_status_if loopBus ();

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Checksum good test, residue form when the inverted variant is used
  function automatic logic crcGood(
    input logic [status_pkg::CRC_W-1:0] value,
    input logic inverted
  );
    logic good;
    good = inverted ? (value == status_pkg::CRC_RESIDUE) : (value == '0);
    return good;
  endfunction : crcGood

  // Whole-address compare; other offsets answer with an error
  function automatic logic isAddr(
    input logic [11:0] addr,
    input logic [11:0] target
  );
    return addr == target;
  endfunction : isAddr

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  assign loopBus.integrator = loopIntegrator;
  assign loopBus.saturationSetting =
    controlWord[status_pkg::CTRL_SAT_LSB +: status_pkg::SAT_W];

  // Limit flags come back one edge late
  loop_limit_monitor loopMonitor (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .loopBus(loopBus.monitor)
  );

  // Clip flag clears when the receiver starts
  sample_clip_detect clipDetect (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .sample(quadratureSample),
    .rxReset(rxReset),
    .clipped(qClipped)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  always_comb begin
    setupPhase = psel && !penable;
    completing = psel && penable && pready;
    hitStatus = isAddr(paddr, status_pkg::STATUS_ADDR);
    hitControl = isAddr(paddr, status_pkg::CONTROL_ADDR);
    next_apbState = apbState;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    unique case (apbState)
      status_pkg::APB_IDLE: begin
        // Answer one cycle after setup, no wait states
        if (setupPhase) begin
          next_apbState = status_pkg::APB_ANSWER;
          next_pready = 1'b1;
          next_prdata = 32'h0000_0000;
          if (!pwrite && hitStatus) begin
            next_prdata = statusWord;
          end else if (!pwrite && hitControl) begin
            next_prdata = controlWord;
          end
          next_pslverr = !(hitControl || (hitStatus && !pwrite));
        end
      end
      status_pkg::APB_ANSWER: begin
        if (completing) begin
          next_apbState = status_pkg::APB_IDLE;
        end else begin
          // Hold the answer until the access edge
          next_pready = pready;
          next_pslverr = pslverr;
        end
      end
      default: begin
        next_apbState = status_pkg::APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      apbState <= status_pkg::APB_IDLE;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      apbState <= next_apbState;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  always_comb begin
    next_controlWord = controlWord;
    // Only the checksum mode bit and the loop band bits 15:8 are kept; the rest read zero
    if (completing && pwrite && hitControl) begin
      next_controlWord = pwdata & status_pkg::CONTROL_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      controlWord <= status_pkg::CONTROL_RESET;
      crcInverted <= 1'b0;
      loopSaturationSetting <= '0;
    end else begin
      controlWord <= next_controlWord;
      crcInverted <= next_controlWord[status_pkg::CTRL_CRC_INV_BIT];
      loopSaturationSetting <=
        next_controlWord[status_pkg::CTRL_SAT_LSB +: status_pkg::SAT_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event tracking

  always_comb begin
    next_rxEnablePrev = rxEnable;
    // Receiver reset happens when the receiver is switched on
    rxReset = rxEnable && !rxEnablePrev;
    next_sofHeld = sofHeld;
    if (rxReset) begin
      next_sofHeld = 1'b0;
    end
    if (sofSeen) begin
      next_sofHeld = 1'b1;
    end

    next_txActivePrev = txActive;
    next_txReadError = txReadError;
    // New transmission starts with a clean error flag
    txStart = txActive && !txActivePrev;
    if (txStart) begin
      next_txReadError = 1'b0;
    end

    if (txActive && txFetchLate) begin
      next_txReadError = 1'b1;
    end

    next_txAbort = txActive && txFetchLate;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      // Edge detectors start at the idle level of their enables
      rxEnablePrev <= 1'b0;
      sofHeld <= 1'b0;
      txActivePrev <= 1'b0;
      txReadError <= 1'b0;
      txAbort <= 1'b0;
    end else begin
      rxEnablePrev <= next_rxEnablePrev;
      sofHeld <= next_sofHeld;
      txActivePrev <= next_txActivePrev;
      txReadError <= next_txReadError;
      txAbort <= next_txAbort;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word assembly

  always_comb begin
    next_statusWord = 32'h0000_0000;
    next_statusWord[status_pkg::CRC_OK_BIT] =
      crcGood(crcValue, controlWord[status_pkg::CTRL_CRC_INV_BIT]);

    next_statusWord[status_pkg::SUBCARRIER_BIT] = subcarrierSeen;
    next_statusWord[status_pkg::SOF_BIT] = sofHeld;
    next_statusWord[status_pkg::OWN_FIELD_BIT] = ownFieldOn;
    next_statusWord[status_pkg::EXT_FIELD_BIT] = externalFieldPresent;
    next_statusWord[status_pkg::Q_CLIP_BIT] = qClipped;

    next_statusWord[status_pkg::LOOP_LIMIT_BIT] = loopBus.atLimit;
    next_statusWord[status_pkg::LOOP_RANGE_BIT] = loopBus.inRange;
    next_statusWord[status_pkg::LOCK_SUPERFINE_BIT] =
      loopFrequencyLockSuperfine;
    next_statusWord[status_pkg::LOCK_FINE_BIT] = loopFrequencyLockFine;
    next_statusWord[status_pkg::LOCK_COARSE_BIT] = loopFrequencyLockCoarse;
    next_statusWord[status_pkg::PHASE_LOCK_BIT] = loopPhaseLocked;
    next_statusWord[status_pkg::LOOP_ENABLED_BIT] = loopEnabled;

    next_statusWord[status_pkg::BUFFER_BUSY_BIT] = bufferManagerBusy;
    next_statusWord[status_pkg::TX_READ_ERR_BIT] = txReadError;
  end

  // Registered so a read sees one coherent snapshot, one cycle late
  // Reset value keeps the checksum flag high
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      statusWord <= status_pkg::STATUS_RESET;
    end else begin
      statusWord <= next_statusWord;
    end
  end

endmodule : contactless_frontend_status

// file: test/contactless_frontend_status_properties.sv
// Concurrent checks on the status bank's APB and status ports.
// Assumes the bind below reaches every instance of the top module.
`timescale 1ns/1ps
module contactless_frontend_status_properties (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [status_pkg::CRC_W-1:0] crcValue,
  input wire logic subcarrierSeen,
  input wire logic ownFieldOn,
  input wire logic bufferManagerBusy,
  input wire logic txActive,
  input wire logic txFetchLate,
  input wire logic txAbort,
  input wire logic crcInverted,
  input wire logic [status_pkg::SAT_W-1:0] loopSaturationSetting
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic wrInv = pwdata[0];
  wire logic [7:0] wrSat = pwdata[15:8];
  ////////////////////////////////////////////////////////////////////////////
  sequence setupSeen;
    psel && !penable;
  endsequence
  sequence doneSeen;
    psel && penable && pready;
  endsequence
  sequence statusRead;
    doneSeen ##0 !pwrite && paddr == status_pkg::STATUS_ADDR;
  endsequence
  a_ready_answer: assert property (
    setupSeen |=> pready ##1 !pready) else $error("pready not one cycle");
  a_status_refused: assert property (
    doneSeen ##0 pwrite && paddr == status_pkg::STATUS_ADDR |-> pslverr)
    else $error("status write accepted");
  a_checksum_ok: assert property (
    statusRead |-> prdata[29] == ($past(crcInverted, 2) ?
    $past(crcValue, 2) == status_pkg::CRC_RESIDUE : $past(crcValue, 2) == 0))
    else $error("checksum flag wrong");
  a_subcarrier_bit: assert property (
    statusRead |-> prdata[28] == $past(subcarrierSeen, 2))
    else $error("subcarrier bit wrong");
  a_own_field: assert property (
    statusRead |-> prdata[26] == $past(ownFieldOn, 2))
    else $error("own field bit wrong");
  a_buffer_busy: assert property (
    statusRead |-> prdata[14] == $past(bufferManagerBusy, 2))
    else $error("busy bit wrong");
  a_reserved_zero: assert property (
    statusRead |-> prdata[31:30] == 2'b00) else $error("reserved bits set");
  a_control_copy: assert property (
    doneSeen ##0 pwrite && paddr == status_pkg::CONTROL_ADDR |=>
    loopSaturationSetting == $past(wrSat) && crcInverted == $past(wrInv))
    else $error("control copy wrong");
  a_abort_pulse: assert property (
    txActive && txFetchLate |=> txAbort) else $error("abort missing");
  a_abort_cause: assert property (
    txAbort |-> $past(txActive) && $past(txFetchLate))
    else $error("abort without cause");
endmodule : contactless_frontend_status_properties
bind contactless_frontend_status contactless_frontend_status_properties chk (
  .mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .crcValue, .subcarrierSeen, .ownFieldOn,
  .bufferManagerBusy, .txActive, .txFetchLate, .txAbort,
  .crcInverted, .loopSaturationSetting);

// file: test/tb.sv
// Self-checking bench for the front-end status bank.
// Assumes the checker file binds itself into the design.
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, ctl, r;
  logic pready, pslverr, err, txAbort, crcInverted;
  logic [7:0] loopSaturationSetting;
  logic [15:0] crcValue = 16'h0000;
  logic subcarrierSeen = 1'b0, sofSeen = 1'b0, ownFieldOn = 1'b0;
  logic externalFieldPresent = 1'b0, rxEnable = 1'b0;
  logic [5:0] quadratureSample = 6'h20;
  logic [9:0] loopIntegrator = 10'h155;
  logic [4:0] locks = 5'h00;
  logic bufferManagerBusy = 1'b0, txActive = 1'b0, txFetchLate = 1'b0;
  int badCount = 0, checksDone = 0, seed = 32'hf10e8a91, i;
  localparam logic [11:0] SA = status_pkg::STATUS_ADDR;
  always #10 mclk = ~mclk;
  contactless_frontend_status dut (.mclk, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .crcValue,
    .subcarrierSeen, .sofSeen, .ownFieldOn, .externalFieldPresent,
    .quadratureSample, .rxEnable, .loopIntegrator,
    .loopFrequencyLockSuperfine(locks[4]), .loopFrequencyLockFine(locks[3]),
    .loopFrequencyLockCoarse(locks[2]), .loopPhaseLocked(locks[1]),
    .loopEnabled(locks[0]), .bufferManagerBusy, .txActive, .txFetchLate,
    .txAbort, .crcInverted, .loopSaturationSetting);
  ////////////////////////////////////////////////////////////////////////////
  task automatic giveVerdict;
    $display("Mismatches %0d of %0d checks", badCount, checksDone);
    if (badCount == 0 && checksDone > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : giveVerdict
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      badCount++;
    end
  endtask : check
  // Entered just after a rising edge; one idle cycle follows each transfer
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    logic ready;
    ready = 1'b0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    // Answer is taken at the edge where pready is seen high
    for (n = 0; n < 20 && !ready; n++) begin
      @(posedge mclk);
      ready = (pready === 1'b1);
      rd = prdata;
      err = pslverr;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    if (!ready) begin
      badCount++;
      giveVerdict();
    end
  endtask : apb
  task automatic rdChk(input string name, input logic [11:0] a,
                       input logic [31:0] exp, input logic [31:0] mask);
    apb(1'b0, a, 32'h0);
    check(name, exp & mask, rd & mask);
  endtask : rdChk
  function automatic logic [31:0] expStatus();
    logic [31:0] s;
    logic [9:0] sat;
    s = 32'h0;
    sat = {2'b00, ctl[15:8]};
    s[29] = ctl[0] ? crcValue == status_pkg::CRC_RESIDUE : crcValue == 0;
    s[28] = subcarrierSeen;
    s[26] = ownFieldOn;
    s[25] = externalFieldPresent;
    s[22] = loopIntegrator == 10'h0 || loopIntegrator == 10'h3ff;
    s[21] = loopIntegrator <= sat || loopIntegrator >= 10'h3ff - sat;
    s[20:16] = locks;
    s[14] = bufferManagerBusy;
    return s;
  endfunction : expStatus
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    ctl = 32'h0;
    rdChk("reset status", SA, status_pkg::STATUS_RESET, '1);
    rdChk("reset control", status_pkg::CONTROL_ADDR, 32'h0, '1);
    apb(1'b1, SA, 32'hffff_ffff);
    check("status write error", 32'h1, {31'h0, err});
    rdChk("status after write", SA, status_pkg::STATUS_RESET, '1);
    apb(1'b0, 12'h040, 32'h0);
    check("unmapped", 32'h0000_0001, {rd[30:0], err});
    repeat (40) begin
      ctl = $random(seed);
      apb(1'b1, status_pkg::CONTROL_ADDR, ctl);
      check("control copy", {23'h0, ctl[15:8], ctl[0]},
            {23'h0, loopSaturationSetting, crcInverted});
      rdChk("control", status_pkg::CONTROL_ADDR,
            ctl & status_pkg::CONTROL_MASK, 32'hffff_ffff);
      r = $random(seed);
      crcValue <= r[0] ? (r[31:16] | 16'h1) :
                  (ctl[0] ? status_pkg::CRC_RESIDUE : 16'h0);
      case (r[2:1])
        2'd0: loopIntegrator <= {10{r[3]}};
        2'd1: loopIntegrator <= {2'b00, ctl[15:8]} + r[3];
        2'd2: loopIntegrator <= 10'h3ff - ctl[15:8] - r[3];
        default: loopIntegrator <= r[12:3];
      endcase
      {subcarrierSeen, sofSeen, ownFieldOn, externalFieldPresent} <= r[14:11];
      {bufferManagerBusy, locks} <= r[20:15];
      rxEnable <= r[21];
      quadratureSample <= r[27:22];
      repeat (4) @(posedge mclk);
      rdChk("status", SA, expStatus(), 32'hf6ff_dfff);
    end
    quadratureSample <= 6'h20;
    sofSeen <= 1'b0;
    // Quiet the live bits so the wide hold mask sees only sticky ones
    {subcarrierSeen, ownFieldOn, externalFieldPresent} <= 3'b000;
    crcValue <= 16'h0001;
    for (i = 0; i < 2; i++) begin
      rxEnable <= 1'b0;
      @(posedge mclk);
      rxEnable <= 1'b1;
      repeat (4) @(posedge mclk);
      rdChk("sticky clear", SA, 32'h0, 32'h0900_0000);
      quadratureSample <= {6{i[0]}};
      sofSeen <= i[0];
      @(posedge mclk);
      quadratureSample <= 6'h20;
      sofSeen <= 1'b0;
      repeat (4) @(posedge mclk);
      rdChk("sticky set", SA, {4'h0, i[0], 3'h1, 24'h0}, 32'h0900_0000);
      rdChk("sticky hold", SA, {4'h0, i[0], 3'h1, 24'h0}, '1 << 24);
    end
    for (i = 0; i < 2; i++) begin
      txActive <= 1'b0;
      @(posedge mclk);
      txActive <= 1'b1;
      repeat (3) @(posedge mclk);
      rdChk("late clear", SA, 32'h0, 32'h0000_2000);
      txFetchLate <= 1'b1;
      @(posedge mclk);
      txFetchLate <= 1'b0;
      @(negedge mclk);
      check("abort pulse", 32'h1, {31'h0, txAbort});
      repeat (4) @(posedge mclk);
      rdChk("late set", SA, 32'h2000, 32'h0000_2000);
    end
    giveVerdict();
  end
endmodule : tb
